/* token_node_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef TOKEN_NODE_CFG_SVH
`define TOKEN_NODE_CFG_SVH
// ----------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_STATUS 3'h0
`define IDX_DIAG 3'h1
`define IDX_PTR_HI 3'h2
`define IDX_PTR_LO 3'h3
`define IDX_DATA 3'h4
`define IDX_SUBSEL 3'h5
`define IDX_CONFIG 3'h6
`define IDX_MUXED 3'h7
`define SUB_PROBE 3'h0
`define SUB_OWN_ID 3'h1
`define SUB_LINE_SETUP_PRIMARY 3'h2
`define SUB_SUCCESSOR 3'h3
`define SUB_LINE_SETUP_SECONDARY 3'h4
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_RI 7
`define BIT_POR 4
`define BIT_RECON 2
`define BIT_TMA 1
`define BIT_TA 0
`define BIT_SELF_RECON 7
`define BIT_DUP 6
`define BIT_RCVACT 5
`define BIT_TOKEN 4
`define BIT_EXCESS_NEGACK_FLAG 3
`define BIT_PROBE 2
`define BIT_NEWNEXT 1
`define BIT_RD_DIR 7
`define BIT_POINTER_AUTOADVANCE 6
`define BIT_SOFT_RST 7
`define MASK_WRITABLE 8'h8f
`define SUBSEL_WRITABLE 8'h07
// ----------------------------------------------------------------------
// Reset values and command codes
// ----------------------------------------------------------------------
`define RST_MASK 8'h00
`define RST_PROBE 8'h00
`define RST_OWN_ID 8'h00
`define RST_CONFIG 8'h18
`define RST_SETUP 8'h00
`define CMD_CLR_FLAGS 8'h1e
`define CMD_POR_CLR 8'h16
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ 25000000
`define PC_RATE_HZ 625000
`define EXEC_RATE_HZ 312500
`define PC_DIV (`CLK_HZ / `PC_RATE_HZ)
`define EXEC_PER_PC (`PC_RATE_HZ / `EXEC_RATE_HZ)
`define RECON_TIME_MS 6720
`define RECON_CYCLES (`RECON_TIME_MS * (`CLK_HZ / 1000))
`endif

/* token_node_pkg.sv */
// Types shared by the node register bank
`default_nettype none
package token_node_pkg;
  typedef enum logic [1:0] {
    st_fetch_op = 2'b00,
    st_fetch_imm = 2'b01,
    st_execute = 2'b10,
    st_delay = 2'b11
  } seq_state_t;
  typedef enum logic [1:0] {
    op_nop = 2'b00,
    op_jump = 2'b01,
    op_core = 2'b10,
    op_core_alt = 2'b11
  } op_kind_t;
endpackage
`default_nettype wire

/* token_node_regs.sv */
// Host register bank and microsequencer of the token-bus node
`default_nettype none
`include "token_node_cfg.svh"
module token_node_regs #(
  parameter int RECON_CYCLES = `RECON_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_inhibit,
  input wire logic tx_avail,
  input wire logic tma_ack,
  input wire logic dup_seen,
  input wire logic rcv_activity,
  input wire logic token_seen,
  input wire logic excess_negack_flag_event,
  input wire logic probe_hit,
  input wire logic successor_load,
  input wire logic [7:0] successor_in,
  input wire logic [7:0] ram_rdata,
  output logic [10:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic [7:0] ram_wdata,
  output logic [7:0] probe_own_station_id,
  output logic [7:0] own_station_id,
  output logic [7:0] node_configuration,
  output logic [7:0] line_setup_primary,
  output logic [7:0] line_setup_secondary,
  output logic [7:0] cmd_code,
  output logic cmd_strobe,
  output logic [7:0] seq_opcode,
  output logic [7:0] seq_operand,
  output logic seq_exec,
  output logic irq
);
  // --------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------
  logic [7:0] interrupt_enable_mask;
  logic [7:0] diagnostic_flags;
  logic [7:0] successor_station_id;
  logic [7:0] ram_data_window;
  logic [2:0] sel;
  logic [10:0] ptr;
  logic rd_dir, pointer_autoadvance;
  logic recon_flag, por_flag;
  logic [2:0] idx;
  logic mapped, acc, wr_acc, rd_acc;
  logic [7:0] wbyte;
  logic [7:0] status_view, rd_mux;
  logic clr_cmd, por_cmd, soft_rst, diag_rd, succ_rd;
  logic data_wr, data_rd, lo_wr, recon_expire;

  assign idx = paddr[4:2];
  assign mapped = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0);
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite && mapped;
  assign rd_acc = acc && !pwrite && mapped;
  assign wbyte = pwdata[7:0];
  assign soft_rst = node_configuration[`BIT_SOFT_RST];
  assign clr_cmd = wr_acc && idx == `IDX_DIAG && wbyte == `CMD_CLR_FLAGS;
  assign por_cmd = wr_acc && idx == `IDX_DIAG && wbyte == `CMD_POR_CLR;
  assign diag_rd = rd_acc && idx == `IDX_DIAG;
  assign succ_rd = rd_acc && idx == `IDX_MUXED && sel == `SUB_SUCCESSOR;
  assign data_wr = wr_acc && idx == `IDX_DATA;
  assign data_rd = rd_acc && idx == `IDX_DATA;
  assign lo_wr = wr_acc && idx == `IDX_PTR_LO;

  always_comb begin
    status_view = 8'h00;
    status_view[`BIT_RI] = rx_inhibit;
    status_view[`BIT_POR] = por_flag;
    status_view[`BIT_RECON] = recon_flag;
    status_view[`BIT_TMA] = tma_ack;
    status_view[`BIT_TA] = tx_avail;
  end

  // Undefined bits read as zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      `IDX_STATUS: rd_mux = status_view;
      `IDX_DIAG: rd_mux = diagnostic_flags;
      `IDX_PTR_HI: rd_mux = {rd_dir, pointer_autoadvance, 3'h0, ptr[10:8]};
      `IDX_PTR_LO: rd_mux = ptr[7:0];
      `IDX_DATA: rd_mux = ram_data_window;
      `IDX_SUBSEL: rd_mux = {5'h00, sel};
      `IDX_CONFIG: rd_mux = {node_configuration[7:2], sel[1:0]};
      `IDX_MUXED: begin
        unique case (sel)
          `SUB_PROBE: rd_mux = probe_own_station_id;
          `SUB_OWN_ID: rd_mux = own_station_id;
          `SUB_LINE_SETUP_PRIMARY: rd_mux = line_setup_primary;
          `SUB_SUCCESSOR: rd_mux = successor_station_id;
          `SUB_LINE_SETUP_SECONDARY: rd_mux = line_setup_secondary;
          default: rd_mux = 8'h00;
        endcase
      end
    endcase
  end

  // --------------------------------------------------------------------
  // APB slave: no wait state, answer built in the setup cycle
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        prdata <= {24'h0, mapped ? rd_mux : 8'h00};
        pslverr <= !mapped;
      end
    end
  end

  // --------------------------------------------------------------------
  // Host-written registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_enable_mask <= `RST_MASK;
      probe_own_station_id <= `RST_PROBE;
      own_station_id <= `RST_OWN_ID;
      node_configuration <= `RST_CONFIG;
      line_setup_primary <= `RST_SETUP;
      line_setup_secondary <= `RST_SETUP;
      sel <= 3'h0;
    end else if (wr_acc) begin
      unique case (idx)
        `IDX_STATUS: interrupt_enable_mask <= wbyte & `MASK_WRITABLE;
        `IDX_SUBSEL: sel <= wbyte[2:0];
        `IDX_CONFIG: begin
          node_configuration <= wbyte;
          sel <= {1'b0, wbyte[1:0]};
        end
        `IDX_MUXED: begin
          unique case (sel)
            `SUB_PROBE: probe_own_station_id <= wbyte;
            `SUB_OWN_ID: own_station_id <= wbyte;
            `SUB_LINE_SETUP_PRIMARY: line_setup_primary <= wbyte;
            `SUB_LINE_SETUP_SECONDARY: line_setup_secondary <= wbyte;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_code <= 8'h00;
      cmd_strobe <= 1'b0;
    end else begin
      cmd_strobe <= wr_acc && idx == `IDX_DIAG;
      if (wr_acc && idx == `IDX_DIAG)
        cmd_code <= wbyte;
    end
  end

  // --------------------------------------------------------------------
  // Status and diagnostic flags; a set beats a clear, except that soft_rst clears diagnostic_flags
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      recon_flag <= 1'b0;
      por_flag <= 1'b1;
    end else begin
      if (recon_expire)
        recon_flag <= 1'b1;
      else if (clr_cmd || soft_rst)
        recon_flag <= 1'b0;
      if (por_cmd)
        por_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      diagnostic_flags <= 8'h00;
    end else if (soft_rst) begin
      diagnostic_flags <= 8'h00;
    end else begin
      if (diag_rd) begin
        diagnostic_flags[`BIT_SELF_RECON] <= 1'b0;
        diagnostic_flags[`BIT_DUP] <= 1'b0;
        diagnostic_flags[`BIT_RCVACT] <= 1'b0;
        diagnostic_flags[`BIT_TOKEN] <= 1'b0;
        diagnostic_flags[`BIT_PROBE] <= 1'b0;
      end
      if (por_cmd)
        diagnostic_flags[`BIT_EXCESS_NEGACK_FLAG] <= 1'b0;
      if (succ_rd)
        diagnostic_flags[`BIT_NEWNEXT] <= 1'b0;
      if (recon_expire)
        diagnostic_flags[`BIT_SELF_RECON] <= 1'b1;
      if (dup_seen)
        diagnostic_flags[`BIT_DUP] <= 1'b1;
      if (rcv_activity)
        diagnostic_flags[`BIT_RCVACT] <= 1'b1;
      if (token_seen)
        diagnostic_flags[`BIT_TOKEN] <= 1'b1;
      if (excess_negack_flag_event)
        diagnostic_flags[`BIT_EXCESS_NEGACK_FLAG] <= 1'b1;
      if (probe_hit && probe_own_station_id != successor_station_id)
        diagnostic_flags[`BIT_PROBE] <= 1'b1;
      if (successor_load)
        diagnostic_flags[`BIT_NEWNEXT] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      successor_station_id <= 8'h00;
    else if (soft_rst)
      successor_station_id <= 8'h00;
    else if (successor_load)
      successor_station_id <= successor_in;
  end

  // Level flags are not latched, so unmasking re-raises a live one
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= (rx_inhibit & interrupt_enable_mask[`BIT_RI])
        | (tx_avail & interrupt_enable_mask[`BIT_TA])
        | (recon_flag & interrupt_enable_mask[`BIT_RECON])
        | (diagnostic_flags[`BIT_EXCESS_NEGACK_FLAG]
          & interrupt_enable_mask[`BIT_EXCESS_NEGACK_FLAG])
        | (diagnostic_flags[`BIT_NEWNEXT]
          & interrupt_enable_mask[`BIT_NEWNEXT]);
  end

  // --------------------------------------------------------------------
  // RAM window
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_dir <= 1'b0;
      pointer_autoadvance <= 1'b0;
      ptr <= 11'h000;
      ram_addr <= 11'h000;
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
      ram_wdata <= 8'h00;
    end else begin
      ram_rd <= 1'b0;
      ram_wr <= 1'b0;
      if (wr_acc && idx == `IDX_PTR_HI) begin
        rd_dir <= wbyte[`BIT_RD_DIR];
        pointer_autoadvance <= wbyte[`BIT_POINTER_AUTOADVANCE];
        ptr[10:8] <= wbyte[2:0];
      end
      if (lo_wr) begin
        ptr[7:0] <= wbyte;
        ram_addr <= {ptr[10:8], wbyte};
        ram_rd <= rd_dir;
      end
      if (data_wr) begin
        ram_addr <= ptr;
        ram_wdata <= wbyte;
        ram_wr <= 1'b1;
        if (pointer_autoadvance)
          ptr <= ptr + 11'h001;
      end
      if (data_rd && pointer_autoadvance) begin
        ptr <= ptr + 11'h001;
        ram_addr <= ptr + 11'h001;
        ram_rd <= rd_dir;
      end
    end
  end

  // Holds garbage until the first prefetch, by design
  logic ram_rd_d;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      ram_rd_d <= 1'b0;
    else
      ram_rd_d <= ram_rd;
  end
  always_ff @(posedge clk) begin
    if (ram_rd_d)
      ram_data_window <= ram_rdata;
  end

  // --------------------------------------------------------------------
  // Microsequencer
  // --------------------------------------------------------------------
  token_node_pkg::seq_state_t state;
  logic [$clog2(`PC_DIV)-1:0] div_cnt;
  logic pc_tick, exec_phase, exec_tick;
  logic [9:0] pc;
  logic [7:0] opcode_reg, imm_reg, delay_cnt;
  logic [31:0] recon_cnt;
  logic [9:0] jump_target;

  function automatic logic [7:0] rom(input logic [9:0] a);
    unique case (a)
      10'h000: rom = 8'h80;
      10'h001: rom = 8'h01;
      10'h002: rom = 8'h00;
      10'h003: rom = 8'h04;
      10'h004: rom = 8'h40;
      default: rom = 8'h00;
    endcase
  endfunction

  assign jump_target = {opcode_reg[1:0], imm_reg};
  assign exec_tick = pc_tick && exec_phase;
  assign recon_expire = recon_cnt == 32'(RECON_CYCLES - 1);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= '0;
      pc_tick <= 1'b0;
      exec_phase <= 1'b0;
    end else begin
      pc_tick <= div_cnt == ($bits(div_cnt))'(`PC_DIV - 1);
      if (div_cnt == ($bits(div_cnt))'(`PC_DIV - 1))
        div_cnt <= '0;
      else
        div_cnt <= div_cnt + 1'b1;
      if (pc_tick)
        exec_phase <= !exec_phase;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      recon_cnt <= 32'h0;
    else if (token_seen || recon_expire || own_station_id == 8'h00)
      recon_cnt <= 32'h0;
    else
      recon_cnt <= recon_cnt + 32'h1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= token_node_pkg::st_fetch_op;
      pc <= 10'h000;
      opcode_reg <= 8'h00;
      imm_reg <= 8'h00;
      delay_cnt <= 8'h00;
      seq_exec <= 1'b0;
      seq_opcode <= 8'h00;
      seq_operand <= 8'h00;
    end else begin
      seq_exec <= 1'b0;
      if (recon_expire) begin
        pc <= 10'h000;
        state <= token_node_pkg::st_fetch_op;
      end else if (own_station_id == 8'h00) begin
        pc <= 10'h000;
        state <= token_node_pkg::st_fetch_op;
      end else if (pc_tick) begin
        unique case (state)
          token_node_pkg::st_fetch_op: begin
            opcode_reg <= rom(pc);
            pc <= pc + 10'h001;
            state <= token_node_pkg::st_fetch_imm;
          end
          token_node_pkg::st_fetch_imm: begin
            imm_reg <= rom(pc);
            pc <= pc + 10'h001;
            state <= token_node_pkg::st_execute;
          end
          token_node_pkg::st_execute: begin
            if (exec_phase) begin
              state <= token_node_pkg::st_fetch_op;
              unique case (token_node_pkg::op_kind_t'(opcode_reg[7:6]))
                token_node_pkg::op_nop: begin
                  delay_cnt <= imm_reg;
                  state <= token_node_pkg::st_delay;
                end
                token_node_pkg::op_jump:
                  pc <= jump_target;
                default: begin
                  seq_exec <= 1'b1;
                  seq_opcode <= opcode_reg;
                  seq_operand <= imm_reg;
                end
              endcase
            end
          end
          token_node_pkg::st_delay: begin
            if (exec_phase) begin
              if (delay_cnt == 8'h00)
                state <= token_node_pkg::st_fetch_op;
              else
                delay_cnt <= delay_cnt - 8'h01;
            end
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_irq_mask_off: assert property (
    $past(interrupt_enable_mask) == 8'h00 |-> !irq)
    else $error("irq raised with mask clear");
  a_mask_reserved: assert property (
    (interrupt_enable_mask & ~`MASK_WRITABLE) == 8'h00)
    else $error("reserved mask bit set");
  a_excess_negack_flag_keeps: assert property (
    diag_rd && !por_cmd && !soft_rst
      && diagnostic_flags[`BIT_EXCESS_NEGACK_FLAG] |=> diagnostic_flags[`BIT_EXCESS_NEGACK_FLAG])
    else $error("diag read cleared excess_negack_flag");
  a_successor_clear: assert property (
    succ_rd && !successor_load && !soft_rst
      |=> !diagnostic_flags[`BIT_NEWNEXT])
    else $error("successor read left flag set");
  a_recon_restart: assert property (
    recon_expire && !soft_rst
      |=> pc == 10'h000 && diagnostic_flags[`BIT_SELF_RECON])
    else $error("recon did not restart sequencer");
  a_nop_holds_pc: assert property (
    state == token_node_pkg::st_delay && !recon_expire
      && own_station_id != 8'h00 |=> $stable(pc))
    else $error("pc moved during delay");
  a_jump_loads: assert property (
    pc_tick && exec_phase && state == token_node_pkg::st_execute
      && opcode_reg[7:6] == 2'b01 && !recon_expire
      && own_station_id != 8'h00 |=> pc == $past(jump_target))
    else $error("jump target not loaded");
  a_low_prefetch: assert property (
    lo_wr && rd_dir |=> ram_rd && ram_addr == {$past(ptr[10:8]),
      $past(wbyte)} ##1 !ram_rd)
    else $error("prefetch missing");
  a_probe_successor: assert property (
    !diagnostic_flags[`BIT_PROBE] && probe_hit
      && probe_own_station_id == successor_station_id
      |=> !diagnostic_flags[`BIT_PROBE])
    else $error("probe reported successor");
  a_pready_wait: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle");

  c_irq_rise: cover property ($rose(irq));
  c_delay_loop: cover property (state == token_node_pkg::st_delay);
  c_recon: cover property (recon_expire);
  c_data_read: cover property (data_rd ##1 ram_rd);
endmodule
`default_nettype wire

/* token_ram_model.sv */
// Behavioural model of the node RAM on the core side of the register bank
`default_nettype none
module token_ram_model (
  input wire logic clk,
  input wire logic [10:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [2048];
  logic [7:0] last = 8'h00;
  // Outside a read answer the bus shows junk, so a late capture shows up
  always @(posedge clk) begin
    if (ram_wr) begin
      mem[ram_addr] <= ram_wdata;
    end
    if (ram_rd) begin
      ram_rdata <= mem[ram_addr];
      last <= mem[ram_addr];
    end else begin
      ram_rdata <= ~last;
    end
  end
endmodule
`default_nettype wire

/* test_token_node_regs.sv */
// Self-checking bench for the node register bank
`default_nettype none
`include "token_node_cfg.svh"
module test_token_node_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, rx_inhibit = 1'b0, tx_avail = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rv;
  logic pready, pslverr, irq, ram_rd, ram_wr, se;
  logic [5:0] ev = 6'h00;
  logic [7:0] succ = 8'h00, ram_rdata, ram_wdata, probe_id;
  logic [7:0] sel [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  logic [7:0] tv [4] = '{8'h5a, 8'h21, 8'h93, 8'h8d};
  logic [10:0] ram_addr;
  int err_total = 0, n_checks = 0, n_rd = 0, k;
  logic [7:0] own_id, cfg, su1, su2, cmd, seq_op;
  logic cmd_stb, seq_ex;
  int cyc = 0, t_exec = -1, n_exec = 0, n_cmd = 0;

  token_node_regs #(.RECON_CYCLES(300)) uut (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_inhibit(rx_inhibit),
    .tx_avail(tx_avail), .tma_ack(1'b0), .dup_seen(ev[0]),
    .rcv_activity(ev[1]), .token_seen(ev[2]), .excess_negack_flag_event(ev[3]),
    .probe_hit(ev[4]), .successor_load(ev[5]), .successor_in(succ),
    .ram_rdata(ram_rdata), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .probe_own_station_id(probe_id),
    .own_station_id(own_id), .node_configuration(cfg),
    .line_setup_primary(su1), .line_setup_secondary(su2), .cmd_code(cmd),
    .cmd_strobe(cmd_stb), .seq_opcode(seq_op), .seq_operand(),
    .seq_exec(seq_ex), .irq(irq));
  token_ram_model ram (.clk(clk), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));

  always #20 clk = ~clk;
  always @(posedge clk) if (ram_rd === 1'b1) n_rd++;
  // Core operations only issue on execute ticks, a whole number of 80-cycle exec periods apart
  always @(posedge clk) begin
    cyc++;
    if (cmd_stb === 1'b1) n_cmd++;
    if (seq_ex === 1'b1) begin
      chk({31'h0, seq_op[7]}, 32'h1);
      if (t_exec >= 0)
        chk((cyc - t_exec) % (`PC_DIV * `EXEC_PER_PC), 0);
      t_exec = cyc;
      n_exec++;
    end
  end

  // ----------------------------------------------------------------
  // Bus and checking tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) err_total++;
    rv = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next request never reassigns psel in this step
    @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    apb(1'b1, {3'h0, i, 2'b00}, d);
  endtask
  task automatic rdc(input logic [2:0] i, input logic [31:0] m, e);
    apb(1'b0, {3'h0, i, 2'b00}, 8'h00);
    chk(rv & m, e);
  endtask
  task automatic irqc(input logic e);
    #1 chk({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic pulse(input logic [5:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 6'h00;
    repeat (2) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdc(3'h6, 32'hff, {24'h0, `RST_CONFIG});
    wr(3'h5, 8'h00);
    rdc(3'h7, 32'hff, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(3'h5, sel[s]);
      wr(3'h7, tv[s]);
    end
    for (int s = 0; s < 4; s++) begin
      wr(3'h5, sel[s]);
      rdc(3'h7, 32'hffffffff, {24'h0, tv[s]});
    end
    chk({24'h0, probe_id}, 32'h5a);
    chk({8'h0, own_id, su1, su2}, 32'h0021938d);
    succ <= 8'h5a;
    pulse(6'h20);
    wr(3'h0, 8'h02);
    irqc(1'b1);
    rdc(3'h1, 32'h02, 32'h02);
    wr(3'h5, 8'h03);
    rdc(3'h7, 32'hff, 32'h5a);
    irqc(1'b0);
    pulse(6'h10);
    rdc(3'h1, 32'h04, 32'h00);
    wr(3'h5, 8'h00);
    wr(3'h7, 8'h21);
    pulse(6'h10);
    rdc(3'h1, 32'h04, 32'h04);
    pulse(6'h0b);
    rdc(3'h1, 32'h7e, 32'h68);
    rdc(3'h1, 32'h7e, 32'h08);
    wr(3'h0, 8'h08);
    irqc(1'b1);
    wr(3'h1, `CMD_CLR_FLAGS);
    irqc(1'b1);
    wr(3'h1, `CMD_POR_CLR);
    irqc(1'b0);
    chk({24'h0, cmd}, {24'h0, `CMD_POR_CLR});
    pulse(6'h03);
    wr(3'h0, 8'h70);
    irqc(1'b0);
    tx_avail <= 1'b1;
    rx_inhibit <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      wr(3'h0, 8'h00);
      irqc(1'b0);
      wr(3'h0, 8'h01);
      irqc(1'b1);
    end
    rdc(3'h0, 32'h81, 32'h81);
    tx_avail <= 1'b0;
    wr(3'h0, 8'h80);
    irqc(1'b1);
    rx_inhibit <= 1'b0;
    wr(3'h0, 8'h04);
    // A token restarts the recon timer, so its expiry lands at a known cycle
    pulse(6'h04);
    wr(3'h1, `CMD_CLR_FLAGS);
    irqc(1'b0);
    repeat (400) @(posedge clk);
    rdc(3'h0, 32'h04, 32'h04);
    irqc(1'b1);
    rdc(3'h1, 32'h80, 32'h80);
    wr(3'h1, `CMD_CLR_FLAGS);
    irqc(1'b0);
    wr(3'h2, 8'h45);
    wr(3'h3, 8'hfe);
    wr(3'h4, 8'h11);
    wr(3'h4, 8'h22);
    wr(3'h4, 8'h33);
    // The model stores on the edge after the write strobe
    @(posedge clk);
    chk({24'h0, ram.mem[11'h5fe]}, 32'h11);
    chk({24'h0, ram.mem[11'h600]}, 32'h33);
    ram.mem[11'h7ff] = 8'ha5;
    ram.mem[11'h000] = 8'h3c;
    wr(3'h2, 8'hc7);
    k = n_rd;
    wr(3'h3, 8'hff);
    repeat (3) @(posedge clk);
    chk(n_rd - k, 32'h1);
    rdc(3'h4, 32'hffffffff, 32'ha5);
    repeat (2) @(posedge clk);
    rdc(3'h4, 32'hffffffff, 32'h3c);
    apb(1'b0, 8'h20, 8'h00);
    chk({31'h0, se}, 32'h1);
    wr(3'h5, 8'h00);
    wr(3'h7, 8'h66);
    wr(3'h6, 8'h98);
    wr(3'h6, 8'h18);
    chk({24'h0, cfg}, 32'h18);
    rdc(3'h7, 32'hff, 32'h66);
    wr(3'h0, 8'h01);
    tx_avail <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    wr(3'h5, 8'h00);
    rdc(3'h7, 32'hff, {24'h0, `RST_PROBE});
    irqc(1'b0);
    chk({31'h0, n_exec > 0}, 32'h1);
    chk(n_cmd, 4);
    give_verdict();
  end

  initial begin
    #(40 * 6000);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
